//--- logic/palette_front_consts.svh
// Constants for the palette pin front end: register codes, field positions, resets, timing.
`ifndef PALETTE_FRONT_CONSTS_SVH
`define PALETTE_FRONT_CONSTS_SVH

`define REG_READ_MASK       4'h2
`define REG_GEN_CTRL        4'h8
`define REG_IN_CLK          4'h9
`define REG_OUT_CLK         4'hA
`define REG_MUX_CTRL        4'hB

`define MUX_PASS_BIT        0
`define MUX_BIG_END_BIT     1
`define GEN_LINE_POL_BIT    0
`define GEN_FRAME_POL_BIT   1
`define GEN_SYNC_EN_BIT     5
`define INCLK_SEL_BIT       0
`define OUTCLK_DIV_LSB      0
`define OUTCLK_DIV_W        3

`define MUX_CTRL_RST        8'h01
`define GEN_CTRL_RST        8'h20
`define IN_CLK_RST          8'h00
`define OUT_CLK_RST         8'h00
`define READ_MASK_RST       8'hFF
`define UNMAPPED_READ       8'h00

`define DOT_CLK_MAX_MHZ     135
`define MCLK_MHZ            10

`endif

//--- logic/palette_front_pkg.sv
// Types shared by the palette pin front end modules.
package palette_front_pkg;

   typedef logic [7:0]  reg_byte_t;
   typedef logic [31:0] pixel_word_t;
   typedef logic [3:0]  reg_sel_t;

   typedef enum logic [1:0] {
      HOST_IDLE = 2'b01,
      HOST_READ = 2'b10
   } host_state_t;

endpackage

//--- logic/pixel_link_if.sv
// Valid/ready link carrying pixel words between the front end and its buffer.
`timescale 1ns/1ps
interface pixel_link_if #(parameter int WIDTH = 32);
   logic [WIDTH-1:0] data;
   logic             valid;
   logic             ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

//--- logic/pin_sync.sv
// Two-flop synchroniser for a bundle of pins, with one falling and one rising edge pulse.
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH    = 8,
   parameter int FALL_BIT = 0,
   parameter int RISE_BIT = 0
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] raw,
   output logic      [WIDTH-1:0] synced,
   output logic                  fall_pulse,
   output logic                  rise_pulse
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] prev_q;

   // Only the second stage and its delayed copy feed any logic.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '1;
         sync_q <= '1;
         prev_q <= '1;
      end else begin
         meta_q <= raw;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign synced     = sync_q;
   assign fall_pulse = prev_q[FALL_BIT] & ~sync_q[FALL_BIT];
   assign rise_pulse = ~prev_q[RISE_BIT] & sync_q[RISE_BIT];

   chk_edge_single : assert property (@(posedge clk) disable iff (!rst_n) // [R11]
      fall_pulse |=> !fall_pulse)
      else $error("falling edge pulse lasted more than one cycle");

endmodule // pin_sync

//--- logic/pixel_skid_buffer.sv
// Two-entry pixel buffer with valid and ready on both sides.
`timescale 1ns/1ps
module pixel_skid_buffer #(
   parameter int DEPTH = 2
) (
   input  wire logic   clk,
   input  wire logic   rst_n,
   pixel_link_if.snk   fill,
   pixel_link_if.src   drain
);

   localparam int PW = (DEPTH > 2) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [$bits(fill.data)-1:0] mem_q [DEPTH];
   logic [PW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
   logic [CW-1:0] count_q, count_d;
   logic          push, pop;

   assign fill.ready  = (count_q != CW'(DEPTH));
   assign drain.valid = (count_q != '0);
   assign drain.data  = mem_q[rd_ptr_q];
   assign push        = fill.valid & fill.ready;
   assign pop         = drain.valid & drain.ready;

   always_comb begin
      wr_ptr_d = wr_ptr_q;
      rd_ptr_d = rd_ptr_q;
      if (push) wr_ptr_d = (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      if (pop)  rd_ptr_d = (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      count_d = count_q + CW'(push) - CW'(pop);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end else begin
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         count_q  <= count_d;
      end
   end

   // Entries carry no reset; only occupied ones are ever presented.
   always_ff @(posedge clk) begin
      if (push) mem_q[wr_ptr_q] <= fill.data;
   end

   chk_count_bound : assert property (@(posedge clk) disable iff (!rst_n) // [R8]
      count_q <= CW'(DEPTH))
      else $error("buffer count exceeded its depth");
   chk_hold_unpopped : assert property (@(posedge clk) disable iff (!rst_n) // [R8]
      drain.valid && !drain.ready |=> drain.valid && $stable(drain.data))
      else $error("stalled output word changed or vanished");
   cov_buffer_full : cover property (@(posedge clk) disable iff (!rst_n)
      !fill.ready);

endmodule // pixel_skid_buffer

//--- logic/palette_pin_front_end.sv
// Pin front end of a video palette: pixel, blank, sync and clock paths plus host strobes.
`timescale 1ns/1ps
`include "palette_front_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// [R1] Pass-through picks dedicated blank, else main blank.
// [R2] Pass-through forces the first dot clock.
// [R3] Either dot clock input may drive dot ticks.
// [R4] Normal mode: active-low syncs through polarity gate.
// [R5] Pass-through forwards syncs with unchanged polarity.
// [R6] Read starts on falling read strobe, drives bus.
// [R7] Four-bit select chooses register; eight-bit data bus.
// [R8] 32-bit pixel port, little or big endian.
// [R9] Programmable video clock output paces pixel transfers.
// [R10] Write data captured on rising write strobe.
// [R11] Host strobes synchronised before touching registers.
module palette_pin_front_end
   import palette_front_pkg::*;
#(
   parameter int BUF_DEPTH = 2
) (
   input  wire logic                          mclk,
   input  wire logic                          rst_n,
   input  wire logic                          first_dot_clock_in,
   input  wire logic                          second_dot_clock_in,
   input  wire palette_front_pkg::pixel_word_t pixel_in,
   input  wire logic                          blank_n_in,
   input  wire logic                          passthrough_blank_n_in,
   input  wire logic                          line_sync_n_in,
   input  wire logic                          frame_sync_n_in,
   input  wire logic                          rd_n,
   input  wire logic                          wr_n,
   input  wire palette_front_pkg::reg_sel_t   register_select,
   input  wire palette_front_pkg::reg_byte_t  host_data_in,
   output palette_front_pkg::reg_byte_t       host_data_out,
   output logic                               host_data_oe,
   output logic                               video_clock_out,
   output logic                               dot_clock_tick,
   output logic                               line_sync_out,
   output logic                               frame_sync_out,
   output logic                               green_sync_level,
   output logic                               blank_n_out,
   output logic                               passthrough_active,
   output palette_front_pkg::pixel_word_t     pixel_word_out,
   output logic                               pixel_valid,
   input  wire logic                          pixel_ready
);

   ////////////////////////////////////////////////////////////////////////////
   // Reset release and pin synchronisers.

   logic [1:0]  rst_pipe_q;
   logic        rst_sync_n;
   logic [13:0] host_s;
   logic        rd_fall, wr_rise;
   logic [37:0] video_s;
   logic        dot0_s, dot1_s, bl_s, pt_bl_s, hs_s, vs_s;
   pixel_word_t pix_s;
   reg_sel_t    sel_s;
   reg_byte_t   data_s;
   logic        rd_s;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) rst_pipe_q <= 2'b00;
      else        rst_pipe_q <= {rst_pipe_q[0], 1'b1};
   end
   assign rst_sync_n = rst_pipe_q[1];

   // Select and data ride with the strobes so they reach the core aligned.
   pin_sync #(.WIDTH(14), .FALL_BIT(13), .RISE_BIT(12)) u_host_sync (  // [R11]
      .clk        (mclk),
      .rst_n      (rst_sync_n),
      .raw        ({rd_n, wr_n, register_select, host_data_in}),
      .synced     (host_s),
      .fall_pulse (rd_fall),
      .rise_pulse (wr_rise)
   );
   assign rd_s   = host_s[13];
   assign sel_s  = host_s[11:8];
   assign data_s = host_s[7:0];

   pin_sync #(.WIDTH(38), .FALL_BIT(0), .RISE_BIT(0)) u_video_sync (
      .clk        (mclk),
      .rst_n      (rst_sync_n),
      .raw        ({first_dot_clock_in, second_dot_clock_in, blank_n_in,
                    passthrough_blank_n_in, line_sync_n_in, frame_sync_n_in, pixel_in}),
      .synced     (video_s),
      .fall_pulse (),
      .rise_pulse ()
   );
   assign {dot0_s, dot1_s, bl_s, pt_bl_s, hs_s, vs_s} = video_s[37:32];
   assign pix_s = video_s[31:0];

   ////////////////////////////////////////////////////////////////////////////
   // Host register access.

   host_state_t host_st_q, host_st_d;
   reg_byte_t   mux_ctrl_q, mux_ctrl_d, gen_ctrl_q, gen_ctrl_d;
   reg_byte_t   in_clk_q, in_clk_d, out_clk_q, out_clk_d;
   reg_byte_t   read_mask_q, read_mask_d, rdata_q, rdata_d, read_val;
   logic        pass;

   assign pass = mux_ctrl_q[`MUX_PASS_BIT];

   always_comb begin
      case (sel_s)                                           // [R7]
         `REG_READ_MASK: read_val = read_mask_q;
         `REG_GEN_CTRL:  read_val = gen_ctrl_q;
         `REG_IN_CLK:    read_val = in_clk_q;
         `REG_OUT_CLK:   read_val = out_clk_q;
         `REG_MUX_CTRL:  read_val = mux_ctrl_q;
         default:        read_val = `UNMAPPED_READ;
      endcase
   end

   always_comb begin
      host_st_d   = host_st_q;
      rdata_d     = rdata_q;
      mux_ctrl_d  = mux_ctrl_q;
      gen_ctrl_d  = gen_ctrl_q;
      in_clk_d    = in_clk_q;
      out_clk_d   = out_clk_q;
      read_mask_d = read_mask_q;
      case (host_st_q)
         HOST_IDLE: begin
            if (rd_fall) begin                               // [R6]
               rdata_d   = read_val;
               host_st_d = HOST_READ;
            end
         end
         HOST_READ: begin
            if (rd_s) host_st_d = HOST_IDLE;
         end
         default: host_st_d = HOST_IDLE;
      endcase
      // Writes act only on the synchronised rising edge, never on the raw pin.
      if (wr_rise) begin                                     // [R10] [R11]
         case (sel_s)                                        // [R7]
            `REG_READ_MASK: read_mask_d = data_s;
            `REG_GEN_CTRL:  gen_ctrl_d  = data_s;
            `REG_IN_CLK:    in_clk_d    = data_s;
            `REG_OUT_CLK:   out_clk_d   = data_s;
            `REG_MUX_CTRL:  mux_ctrl_d  = data_s;
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         host_st_q   <= HOST_IDLE;
         rdata_q     <= 8'h00;
         mux_ctrl_q  <= `MUX_CTRL_RST;
         gen_ctrl_q  <= `GEN_CTRL_RST;
         in_clk_q    <= `IN_CLK_RST;
         out_clk_q   <= `OUT_CLK_RST;
         read_mask_q <= `READ_MASK_RST;
      end else begin
         host_st_q   <= host_st_d;
         rdata_q     <= rdata_d;
         mux_ctrl_q  <= mux_ctrl_d;
         gen_ctrl_q  <= gen_ctrl_d;
         in_clk_q    <= in_clk_d;
         out_clk_q   <= out_clk_d;
         read_mask_q <= read_mask_d;
      end
   end

   assign host_data_out = rdata_q;
   assign host_data_oe  = (host_st_q == HOST_READ);          // [R6]

   ////////////////////////////////////////////////////////////////////////////
   // Dot clock selection and video clock divider.

   // Dot clock edges are seen by sampling, so only rates well below mclk
   // resolve here; the core cannot follow rates up to DOT_CLK_MAX_MHZ.
   logic                     sel_second, dot_sel, dot_prev_q, dot_prev_d;
   logic [`OUTCLK_DIV_W-1:0] div_cnt_q, div_cnt_d, div_limit;
   logic                     video_clock_out_q, video_clock_out_d, take_pixel;

   pixel_link_if #(.WIDTH(32)) fill_link ();
   pixel_link_if #(.WIDTH(32)) drain_link ();

   assign sel_second     = ~pass & in_clk_q[`INCLK_SEL_BIT];  // [R2]
   assign dot_sel        = sel_second ? dot1_s : dot0_s;      // [R3]
   assign dot_clock_tick = dot_sel & ~dot_prev_q;             // [R3]
   assign div_limit      = out_clk_q[`OUTCLK_DIV_LSB +: `OUTCLK_DIV_W];

   always_comb begin
      dot_prev_d = dot_sel;
      div_cnt_d  = div_cnt_q;
      video_clock_out_d     = video_clock_out_q;
      // A full buffer freezes the video clock, which holds off the pixel source.
      if (dot_clock_tick && fill_link.ready) begin            // [R9]
         if (div_cnt_q == div_limit) begin
            div_cnt_d = '0;
            video_clock_out_d    = ~video_clock_out_q;
         end else begin
            div_cnt_d = div_cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         // The pin synchroniser resets high, so a low start would fake a tick.
         dot_prev_q <= 1'b1;
         div_cnt_q  <= '0;
         video_clock_out_q     <= 1'b0;
      end else begin
         dot_prev_q <= dot_prev_d;
         div_cnt_q  <= div_cnt_d;
         video_clock_out_q     <= video_clock_out_d;
      end
   end

   assign video_clock_out = video_clock_out_q;                          // [R9]
   assign take_pixel      = video_clock_out_d & ~video_clock_out_q;

   ////////////////////////////////////////////////////////////////////////////
   // Pixel capture and buffering.

   pixel_word_t push_data_q, push_data_d, ordered;
   logic        push_q, push_d;

   assign ordered = mux_ctrl_q[`MUX_BIG_END_BIT] ?           // [R8]
                    {pix_s[7:0], pix_s[15:8], pix_s[23:16], pix_s[31:24]} : pix_s;

   always_comb begin
      push_d      = take_pixel;
      push_data_d = take_pixel ? ordered : push_data_q;       // [R8]
   end

   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         push_q      <= 1'b0;
         push_data_q <= 32'h0000_0000;
      end else begin
         push_q      <= push_d;
         push_data_q <= push_data_d;
      end
   end

   assign fill_link.valid = push_q;
   assign fill_link.data  = push_data_q;

   pixel_skid_buffer #(.DEPTH(BUF_DEPTH)) u_buffer (
      .clk   (mclk),
      .rst_n (rst_sync_n),
      .fill  (fill_link.snk),
      .drain (drain_link.src)
   );

   assign pixel_word_out   = drain_link.data;
   assign pixel_valid      = drain_link.valid;
   assign drain_link.ready = pixel_ready;

   ////////////////////////////////////////////////////////////////////////////
   // Blank and sync paths.

   logic blank_q, blank_d, line_q, line_d, frame_q, frame_d, green_q, green_d;

   always_comb begin
      blank_d = pass ? pt_bl_s : bl_s;                       // [R1]
      if (pass) begin
         line_d  = hs_s;                                     // [R5]
         frame_d = vs_s;                                     // [R5]
         green_d = 1'b0;
      end else begin
         line_d  = ~hs_s ^ gen_ctrl_q[`GEN_LINE_POL_BIT];     // [R4]
         frame_d = ~vs_s ^ gen_ctrl_q[`GEN_FRAME_POL_BIT];    // [R4]
         green_d = gen_ctrl_q[`GEN_SYNC_EN_BIT] & (~hs_s | ~vs_s);  // [R4]
      end
   end

   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         blank_q <= 1'b0;
         line_q  <= 1'b1;
         frame_q <= 1'b1;
         green_q <= 1'b0;
      end else begin
         blank_q <= blank_d;
         line_q  <= line_d;
         frame_q <= frame_d;
         green_q <= green_d;
      end
   end

   assign blank_n_out        = blank_q;
   assign line_sync_out      = line_q;
   assign frame_sync_out     = frame_q;
   assign green_sync_level   = green_q;
   assign passthrough_active = pass;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_sync_n);

   chk_blank_source : assert property (                       // [R1]
      $stable(pass) |=> blank_n_out == ($past(pass) ? $past(pt_bl_s) : $past(bl_s)))
      else $error("blank taken from the wrong input");
   chk_pass_first_clk : assert property (pass |-> !sel_second) // [R2]
      else $error("pass-through not on the first dot clock");
   chk_dot_tick_edge : assert property (                      // [R3]
      dot_clock_tick |=> !dot_clock_tick)
      else $error("dot tick longer than one cycle");
   chk_normal_sync : assert property (                        // [R4]
      !pass && $stable(gen_ctrl_q) |=>
      line_sync_out == (!$past(hs_s) ^ $past(gen_ctrl_q[`GEN_LINE_POL_BIT])))
      else $error("normal mode line sync polarity wrong");
   chk_pass_sync : assert property (                          // [R5]
      pass && $stable(pass) |=> frame_sync_out == $past(vs_s) && !green_sync_level)
      else $error("pass-through sync altered");
   chk_read_drive : assert property (                         // [R6]
      rd_fall && host_st_q == HOST_IDLE |=> host_data_oe && host_data_out == $past(read_val))
      else $error("read did not drive selected data");
   chk_read_release : assert property (                       // [R6]
      host_data_oe && rd_s |=> !host_data_oe)
      else $error("data bus held after read strobe rose");
   chk_write_decode : assert property (                       // [R7] [R10]
      wr_rise && sel_s == `REG_MUX_CTRL |=> mux_ctrl_q == $past(data_s))
      else $error("write to mux control lost");
   chk_write_sync : assert property (                         // [R11]
      !$past(wr_rise) |-> $stable(gen_ctrl_q))
      else $error("register changed without a host write");
   chk_byte_order : assert property (                         // [R8]
      take_pixel && mux_ctrl_q[`MUX_BIG_END_BIT] |=>
      fill_link.valid && push_data_q[7:0] == $past(pix_s[31:24]))
      else $error("big endian byte order wrong");
   chk_video_clock_out_stall : assert property (                         // [R9]
      !fill_link.ready |=> $stable(video_clock_out))
      else $error("video clock ran while buffer full");

   cov_passthrough : cover property ($fell(pass));
   cov_big_endian  : cover property (take_pixel && mux_ctrl_q[`MUX_BIG_END_BIT]);
   cov_host_read   : cover property (rd_fall ##1 host_data_oe);
   cov_stall       : cover property (pixel_valid && !pixel_ready ##1 !fill_link.ready);

endmodule // palette_pin_front_end

//--- tb/graphics_ctrl_model.sv
// Behavioural graphics controller: dot clocks and pixel words paced by the video clock.
`timescale 1ns/1ps
module graphics_ctrl_model
   import palette_front_pkg::*;
(
   input  wire logic                           mclk,
   input  wire logic                           run,
   input  wire logic                           use_second,
   input  wire palette_front_pkg::pixel_word_t rnd_word,
   input  wire logic                           video_clock_out,
   output logic                                first_dot_clock_in,
   output logic                                second_dot_clock_in,
   output palette_front_pkg::pixel_word_t      pixel_in,
   output logic                                note_valid,
   output palette_front_pkg::pixel_word_t      note_word
);
   logic [1:0] phase_q;
   logic       dot_q;
   logic       video_clock_out_q;

   initial begin
      phase_q = 2'h0;
      dot_q = 1'h0;
      video_clock_out_q = 1'h0;
      note_valid = 1'h0;
      note_word = 32'h0;
      pixel_in = 32'h0;
      first_dot_clock_in = 1'h0;
      second_dot_clock_in = 1'h0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // A word is held until the video clock rises, so a frozen clock never loses one.
   always @(posedge mclk) begin
      #1;
      note_valid = 1'h0;
      if (video_clock_out && !video_clock_out_q) begin
         note_valid = 1'h1;
         note_word = pixel_in;
         pixel_in = rnd_word;
      end
      video_clock_out_q = video_clock_out;
      phase_q = run ? phase_q + 2'h1 : 2'h0;
      if (!run)
         dot_q = 1'h0;
      else if (phase_q == 2'h0)
         dot_q = !dot_q;
      // Only the chosen pin toggles; the other stands still at 0.
      first_dot_clock_in = dot_q && !use_second;
      second_dot_clock_in = dot_q && use_second;
   end
endmodule // graphics_ctrl_model

//--- tb/test_palette_pin_front_end.sv
// Self-checking bench for the palette pin front end.
`timescale 1ns/1ps
`include "palette_front_consts.svh"
module test_palette_pin_front_end
   import palette_front_pkg::*;
;
   logic        mclk, rst_n, blank_n_in, passthrough_blank_n_in, line_sync_n_in;
   logic        frame_sync_n_in, rd_n, wr_n, pixel_ready, first_dot_clock_in;
   logic        second_dot_clock_in, host_data_oe, video_clock_out, dot_clock_tick;
   logic        line_sync_out, frame_sync_out, green_sync_level, blank_n_out;
   logic        passthrough_active, pixel_valid, note_valid, run, use_second, big_mode;
   logic        stall_en, hold_ready, measure, seen_rise, video_clock_out_seen, oe_seen;
   reg_sel_t    register_select;
   reg_byte_t   host_data_in, host_data_out;
   pixel_word_t pixel_in, pixel_word_out, note_word, rnd;
   int          err_total, total_checks, popped, tick_cnt, tick_sum, note_cnt, n, i, p;
   pixel_word_t exp_px[$];
   reg_byte_t   exp_rd[$];

   palette_pin_front_end dut_u (.mclk, .rst_n, .first_dot_clock_in, .second_dot_clock_in,
      .pixel_in, .blank_n_in, .passthrough_blank_n_in, .line_sync_n_in, .frame_sync_n_in,
      .rd_n, .wr_n, .register_select, .host_data_in, .host_data_out, .host_data_oe,
      .video_clock_out, .dot_clock_tick, .line_sync_out, .frame_sync_out, .green_sync_level,
      .blank_n_out, .passthrough_active, .pixel_word_out, .pixel_valid, .pixel_ready);
   graphics_ctrl_model partner_u (.mclk, .run, .use_second, .rnd_word(rnd), .video_clock_out,
      .first_dot_clock_in, .second_dot_clock_in, .pixel_in, .note_valid, .note_word);

   always #50 mclk = ~mclk;

   function automatic pixel_word_t xs(input pixel_word_t x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic cyc(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic timeout(input string what);
      err_total++;
      $display("MISMATCH %s expected done seen timeout", what);
      end_sim();
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Host strobes are held well past the synchroniser depth on both sides.
   task automatic host_write(input reg_sel_t sel, input reg_byte_t val);
      register_select = sel;
      host_data_in = val;
      cyc(4);
      wr_n = 1'h0;
      cyc(4);
      wr_n = 1'h1;
      cyc(4);
      host_data_in = ~val;
      cyc(3);
   endtask

   task automatic host_read(input reg_sel_t sel, input reg_byte_t exp);
      register_select = sel;
      cyc(4);
      exp_rd.push_back(exp);
      rd_n = 1'h0;
      for (n = 0; !host_data_oe; n++) begin
         if (n == 10)
            timeout("read start");
         cyc(1);
      end
      cyc(2);
      rd_n = 1'h1;
      for (n = 0; host_data_oe; n++) begin
         if (n == 10)
            timeout("read end");
         cyc(1);
      end
      cyc(3);
   endtask

   task automatic wait_words(input int k);
      for (n = popped + k; popped < n; ) begin
         if (i++ == 4000)
            timeout("pixel stream");
         cyc(1);
      end
   endtask

   task automatic stop_stream();
      run = 1'h0;
      cyc(40);
      check("drained", exp_px.size(), 0);
   endtask

   task automatic static_pins(input logic pass);
      for (p = 0; p < 4; p++) begin
         passthrough_blank_n_in = p[0];
         blank_n_in = !p[0];
         line_sync_n_in = p[0];
         frame_sync_n_in = p[1];
         cyc(5);
         check("blank", blank_n_out, pass ? p[0] : !p[0]);
         if (pass) begin
            check("line_pass", line_sync_out, p[0]);
            check("frame_pass", frame_sync_out, p[1]);
         end else begin
            check("line_norm", line_sync_out, !p[0] ^ i[0]);
            check("frame_norm", frame_sync_out, !p[1] ^ i[0]);
            if (p != 0)
               check("green", green_sync_level, p != 3);
         end
      end
   endtask

   always @(posedge mclk) begin
      #1;
      rnd = xs(rnd);
      pixel_ready = hold_ready ? 1'h0 : (stall_en ? rnd[3] : 1'h1);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Results are matched against the oldest expectation noted by the driver.
   always @(posedge mclk) begin
      if (note_valid) begin
         note_cnt++;
         exp_px.push_back(big_mode ? pixel_word_t'({<<8{note_word}}) : note_word);
      end
      if (pixel_valid && pixel_ready) begin
         popped++;
         if (exp_px.size() == 0)
            check("pixel_extra", 1, 0);
         else
            check("pixel_word", pixel_word_out, exp_px.pop_front());
      end
      if (host_data_oe && !oe_seen)
         check("read_data", host_data_out, exp_rd.pop_front());
      oe_seen = host_data_oe;
      tick_sum += dot_clock_tick;
      if (video_clock_out && !video_clock_out_seen) begin
         if (measure && seen_rise)
            check("video_clock_out_ticks", tick_cnt, 6);
         seen_rise = measure;
         tick_cnt = 0;
      end else
         tick_cnt += dot_clock_tick;
      video_clock_out_seen = video_clock_out;
   end

   initial begin
      {mclk, rst_n, rd_n, wr_n, run, use_second, big_mode} = 7'h18;
      {stall_en, hold_ready, measure, seen_rise, video_clock_out_seen, oe_seen} = 6'h0;
      {blank_n_in, passthrough_blank_n_in, line_sync_n_in, frame_sync_n_in} = 4'hF;
      register_select = 4'h0;
      host_data_in = 8'hA5;
      pixel_ready = 1'h1;
      rnd = 32'h36;
      cyc(20);
      check("oe_reset", host_data_oe, 0);
      check("pass_reset", passthrough_active, 1);
      rst_n = 1'h1;
      cyc(6);
      host_read(`REG_MUX_CTRL, `MUX_CTRL_RST);
      host_read(`REG_GEN_CTRL, `GEN_CTRL_RST);
      host_read(`REG_READ_MASK, `READ_MASK_RST);
      host_write(`REG_READ_MASK, 8'h5A);
      host_read(`REG_READ_MASK, 8'h5A);
      host_write(4'h6, 8'hC3);
      host_read(4'h6, `UNMAPPED_READ);
      static_pins(1'h1);
      host_write(`REG_MUX_CTRL, 8'h00);
      check("pass_off", passthrough_active, 0);
      for (i = 0; i < 2; i++) begin
         host_write(`REG_GEN_CTRL, i[0] ? 8'h23 : 8'h20);
         static_pins(1'h0);
      end
      host_write(`REG_GEN_CTRL, 8'h03);
      cyc(5);
      check("green_off", green_sync_level, 0);
      stall_en = 1'h1;
      run = 1'h1;
      wait_words(20);
      hold_ready = 1'h1;
      cyc(150);
      n = note_cnt;
      cyc(60);
      check("frozen", note_cnt, n);
      hold_ready = 1'h0;
      wait_words(6);
      stop_stream();
      host_write(`REG_MUX_CTRL, 8'h02);
      host_write(`REG_IN_CLK, 8'h01);
      host_write(`REG_OUT_CLK, 8'h02);
      {big_mode, use_second, stall_en, measure, run} = 5'h1B;
      wait_words(8);
      stop_stream();
      {big_mode, measure} = 2'h0;
      host_write(`REG_MUX_CTRL, 8'h01);
      run = 1'h1;
      cyc(100);
      n = tick_sum;
      cyc(100);
      check("pt_second_off", tick_sum, n);
      use_second = 1'h0;
      cyc(100);
      check("pt_first_on", tick_sum > n, 1);
      end_sim();
   end
endmodule // test_palette_pin_front_end
